// file: include/qrc_pkg.sv
package qrc_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam int DATA_W = 16;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [2:0] OFS_CTRL = 3'h0;
  localparam logic [2:0] OFS_POS = 3'h1;
  localparam logic [2:0] OFS_REV = 3'h2;
  localparam logic [2:0] OFS_MAXPOS = 3'h3;
  localparam logic [2:0] OFS_POSCMP = 3'h4;
  localparam logic [2:0] OFS_SHRCMP = 3'h5;
  localparam logic [2:0] OFS_FLAGS = 3'h6;
  localparam logic [2:0] OFS_IRQEN = 3'h7;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTL_POSMODE = 0;
  localparam int CTL_REVMODE = 2;
  localparam int CTL_CLRGATE = 4;
  localparam int CTL_MASK = 5;
  localparam int CTL_RSEL = 7;
  localparam int CTL_SWAP = 8;
  localparam int CTL_W = 9;

  // ----------------------------------------------------------------
  // Flag and enable bits
  // ----------------------------------------------------------------
  localparam int FLG_CDC = 0;
  localparam int FLG_IDX = 1;
  localparam int FLG_OVF = 2;
  localparam int FLG_UNF = 3;
  localparam int FLG_SHR = 4;
  localparam int FLG_POS = 5;
  localparam int FLG_DUAL = 6;
  localparam int FLG_OOR = 7;
  localparam int FLG_DIR = 8;
  localparam int FLG_N = 8;
  localparam int EN_CDC = 0;
  localparam int EN_WRAP = 1;
  localparam int EN_SHR = 2;
  localparam int EN_POS = 3;
  localparam int EN_DUAL = 4;
  localparam int EN_OOR = 5;
  localparam int EN_N = 6;

  // ----------------------------------------------------------------
  // Reset values and constants
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] RST_ZERO = 16'h0000;
  localparam logic [DATA_W-1:0] RST_MAXPOS = 16'hFFFF;
  localparam logic [DATA_W-1:0] ONE = 16'h0001;
  localparam logic [DATA_W-1:0] ALL_ONES = 16'hFFFF;
  localparam logic [1:0] MASK_NONE = 2'h0;

  // ----------------------------------------------------------------
  // Modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    REV_OFF = 2'b00,
    REV_INDEX = 2'b01,
    REV_WRAP = 2'b10,
    REV_BOTH = 2'b11
  } qrc_rev_e;

  typedef enum logic [1:0] {
    POS_OFF = 2'b00,
    POS_UPDN = 2'b01,
    POS_PHASE = 2'b10,
    POS_DIR = 2'b11
  } qrc_pos_e;

endpackage : qrc_pkg

// file: tb/qrc_encoder_model.sv
`timescale 1ns/1ps
`default_nettype none

module qrc_encoder_model (
  // Clock
  input wire logic mclk,
  // Encoder pins
  output logic phaseA,
  output logic phaseB,
  output logic indexIn
);
  // ------------------------------------------------------------
  // Pin drive
  // ------------------------------------------------------------
  initial begin
    phaseA = 1'b0;
    phaseB = 1'b0;
    indexIn = 1'b0;
  end

  task automatic drive(input logic a, input logic b, input logic z);
    @(posedge mclk);
    phaseA <= a;
    phaseB <= b;
    indexIn <= z;
    repeat (6) @(posedge mclk);
  endtask : drive
endmodule : qrc_encoder_model

`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import qrc_pkg::*;
;
  logic mclk;
  logic rst_n;
  logic phaseA, phaseB, indexIn;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wrData, rdData, posCount, revCount, rd;
  logic wrStb, rdStb, irq;
  int miscompares, cmp_count, seed, i;
  int pos, rev, maxP, rmode, mfield, mcnt, dirDn, fl, gated, aL, bL, zL;

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  qrc_counter dut_u (.mclk(mclk), .rst_n(rst_n), .phaseA(phaseA), .phaseB(phaseB), .indexIn(indexIn),
    .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .irq(irq),
    .posCount(posCount), .revCount(revCount));
  qrc_encoder_model enc_u (.mclk(mclk), .phaseA(phaseA), .phaseB(phaseB), .indexIn(indexIn));

  // ------------------------------------------------------------
  // Checks and bus
  // ------------------------------------------------------------
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge mclk);
    wrStb <= 1'b0;
  endtask : wr

  task automatic rdReg(input logic [ADDR_W-1:0] a, output logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge mclk);
    rdStb <= 1'b0;
    #1 d = rdData;
  endtask : rdReg

  task automatic chk();
    cmp(posCount, 16'(pos), "pos");
    cmp(revCount, 16'(rev), "rev");
  endtask : chk

  task automatic chkFlags();
    rdReg(OFS_FLAGS, rd);
    cmp(rd & 16'h010E, 16'(fl & 32'h10E), "flags");
    cmp({15'h0000, irq}, ((fl & 14) != 0) ? 16'h0001 : 16'h0000, "irq set");
    wr(OFS_FLAGS, 16'h0000);
    fl = fl & 32'h100;
    #1 cmp({15'h0000, irq}, 16'h0000, "irq clear");
  endtask : chkFlags

  // ------------------------------------------------------------
  // Reference model
  // ------------------------------------------------------------
  task automatic mStep(int dn);
    int mk;
    int ev;
    mk = (dn == dirDn && mcnt != 0 && (rmode == 0 || rmode == 3));
    ev = 0;
    if (dn != dirDn) mcnt = -1;
    else if (mcnt > 0) mcnt--;
    dirDn = dn;
    fl = (fl & 32'hFF) | (dn << 8);
    if (!dn && pos == maxP) begin
      fl |= 4;
      ev = 1;
      pos = (rmode == 1) ? pos + 1 : 0;
      if (rmode >= 2 && !mk) rev++;
    end else if (dn && pos == 0) begin
      fl |= 8;
      ev = 1;
      pos = maxP;
      if (rmode >= 2 && !mk) rev--;
    end else pos += dn ? -1 : 1;
    pos &= 32'hFFFF;
    rev &= 32'hFFFF;
    if (mcnt < 0) mcnt = 0;
    else if (ev && (rmode == 0 || rmode == 3)) mcnt = mfield;
  endtask : mStep

  task automatic mIdx();
    int mk;
    mk = (mcnt != 0 && (rmode == 0 || rmode == 3));
    if (rmode != 2 && !mk) begin
      pos = 0;
      fl |= 2;
      if (rmode & 1) rev = (rev + (dirDn ? -1 : 1)) & 32'hFFFF;
    end
    if (rmode == 0 || rmode == 3) mcnt = mfield;
  endtask : mIdx

  // ------------------------------------------------------------
  // Stimulus
  // ------------------------------------------------------------
  task automatic setCtl(int rm, int g, int mf);
    rmode = rm;
    gated = g;
    mfield = mf;
    mcnt = 0;
    wr(OFS_CTRL, 16'(3 | (rm << 2) | (g << 4) | (mf << 5)));
  endtask : setCtl

  task automatic pins(int a, int b, int z);
    aL = a;
    bL = b;
    zL = z;
    enc_u.drive(a[0], b[0], z[0]);
  endtask : pins

  task automatic step(int dn);
    pins(!dn, 0, zL);
    pins(!dn, 1, zL);
    if (!gated || zL) mStep(dn);
    chk();
  endtask : step

  task automatic idx();
    pins(aL, bL, 1);
    if (!gated) mIdx();
    chk();
    pins(aL, bL, 0);
  endtask : idx

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out

  initial begin
    repeat (40000) @(posedge mclk);
    miscompares++;
    close_out();
  end

  initial begin
    seed = 32'hc0f24589;
    rst_n = 1'b0;
    addr = '0;
    wrData = '0;
    wrStb = 1'b0;
    rdStb = 1'b0;
    miscompares = 0;
    cmp_count = 0;
    {pos, rev, rmode, mfield, mcnt, dirDn, fl, gated, aL, bL, zL} = '0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    rdReg(OFS_MAXPOS, rd);
    cmp(rd, RST_MAXPOS, "maxpos reset");
    rdReg(OFS_REV, rd);
    cmp(rd, 16'h0000, "rev reset");
    maxP = 3;
    wr(OFS_MAXPOS, 16'h0003);
    wr(OFS_IRQEN, 16'h0002);
    $display("reset values done");
    setCtl(0, 0, 0);
    wr(OFS_REV, 16'h0005);
    rev = 5;
    repeat (4) step(0);
    chkFlags();
    step(0);
    idx();
    $display("mode 00 done");
    setCtl(1, 0, 0);
    repeat (4) step(0);
    idx();
    step(1);
    idx();
    chkFlags();
    pins(1, 0, 0);
    pins(1, 1, 1);
    mStep(0);
    mIdx();
    chk();
    pins(1, 1, 0);
    $display("mode 01 done");
    setCtl(3, 0, 0);
    repeat (5) step(0);
    idx();
    repeat (2) step(1);
    idx();
    step(0);
    pins(1, 0, 0);
    pins(0, 1, 1);
    mIdx();
    chk();
    pins(0, 1, 0);
    chkFlags();
    $display("mode 11 done");
    maxP = 1;
    wr(OFS_MAXPOS, 16'h0001);
    setCtl(3, 0, 3);
    repeat (4) step(0);
    maxP = 3;
    wr(OFS_MAXPOS, 16'h0003);
    step(0);
    idx();
    step(1);
    idx();
    $display("mask done");
    setCtl(0, 1, 0);
    step(0);
    pins(aL, bL, 1);
    chk();
    step(0);
    pins(aL, bL, 0);
    idx();
    $display("gate done");
    setCtl(2, 0, 0);
    maxP = 3 + ($random(seed) & 3);
    wr(OFS_MAXPOS, 16'(maxP));
    for (i = 0; i < 40; i++) begin
      step($random(seed) & 1);
      if (i % 8 == 0) idx();
    end
    chkFlags();
    $display("mode 10 done");
    setCtl(0, 0, 0);
    pins(0, 0, 0);
    wr(OFS_CTRL, 16'h0000);
    wr(OFS_POS, 16'h0002);
    pos = 2;
    rdReg(OFS_POS, rd);
    cmp(rd, 16'h0002, "pos write");
    chk();
    wr(OFS_CTRL, 16'h0001);
    pins(1, 0, 0);
    mStep(0);
    chk();
    pins(1, 1, 0);
    mStep(1);
    chk();
    wr(OFS_CTRL, 16'h0002);
    pins(0, 1, 0);
    mStep(0);
    chk();
    pins(0, 0, 0);
    mStep(0);
    chk();
    wr(OFS_CTRL, 16'h0101);
    pins(0, 1, 0);
    mStep(0);
    chk();
    pins(1, 1, 0);
    mStep(1);
    chk();
    chkFlags();
    $display("position modes done");
    close_out();
  end
endmodule : tb_top

`default_nettype wire

// file: verilog/qrc_counter.sv
// Contract
// - Mode 00: revolution count frozen; index clear and overflow reset the position.
// - Mode 01 with index clear: revolution moves on index edges only.
// - Mode 01: index edge counts up when direction is 0, down when 1.
// - Mode 01: overflow keeps position counting upward and sets overflow flag.
// - Index coinciding with a count step follows that step's direction.
// - Index with A and B edges together uses the stored direction.
// - Mode 10: revolution counts on overflow/underflow only; index ignored.
// - Mode 11: up on index while incrementing or overflow; down likewise.
// - Mode 11 with index clear: position resets on index or overflow.
// - Interrupt asserts when any flag and its enable are both 1.
// - Underflow below zero reloads maximum; passing maximum wraps to zero except in mode 01.
// - Modes 00, 10, 11: overflow sets flag and resets position.
// - Mode 10: underflow decrements revolution and sets underflow flag.
// - Reset mask acts only in modes 00 and 11, any position mode.
// - Index, overflow or underflow loads mask counter from mask field.
// - Same-direction counts decrement mask; nonzero mask suppresses index resets and revolutions.
// - Direction inversion forces mask counter to zero.
// - Mode field or direction change releases an active mask.
// - While masked, overflow clears and underflow reloads, flags set, revolutions held.
// - Direction comes only from phase A and B; index never alters it.
// - Index is a clear when select bit is 0, a count gate when 1.
`timescale 1ns/1ps
`default_nettype none

module qrc_counter
  import qrc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Encoder pins
  input wire logic phaseA,
  input wire logic phaseB,
  input wire logic indexIn,
  // Register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [DATA_W-1:0] rdData,
  // Status
  output logic irq,
  output logic [DATA_W-1:0] posCount,
  output logic [DATA_W-1:0] revCount
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [CTL_W-1:0] ctrl_r;
  logic [DATA_W-1:0] pos_r, pos_nxt;
  logic [DATA_W-1:0] rev_r, rev_nxt;
  logic [DATA_W-1:0] maxPos_r, posCmp_r, shrCmp_r;
  logic [FLG_N-1:0] flags_r, flagSet;
  logic [EN_N-1:0] irqEn_r;
  logic [DATA_W-1:0] rdData_r;
  logic [1:0] maskCnt_r;
  logic dir_r;
  logic [CTL_W-1:0] ctrlPrev_r;
  logic [2:0] sync1_r, sync2_r;
  logic aPrev_r, bPrev_r, zPrev_r;

  qrc_pos_e posMode;
  qrc_rev_e revMode;
  logic clearSel, maskable, maskActive, modeChange;
  logic phase_a_input, phase_b_input, index_input, aRise, aFall, bRise, bFall, aEdge, bEdge, zRise;
  logic stepUp, stepDn, posStep, inversion, idxEv, idxUp;
  logic ovf, unf, revInc, revDec, wrPos, wrRev, wrFlags;

  assign posMode = qrc_pos_e'(ctrl_r[CTL_POSMODE +: 2]);
  assign revMode = qrc_rev_e'(ctrl_r[CTL_REVMODE +: 2]);
  assign clearSel = ~ctrl_r[CTL_CLRGATE];
  assign wrPos = wrStb && (addr == OFS_POS) && (posMode == POS_OFF);
  assign wrRev = wrStb && (addr == OFS_REV) && (revMode == REV_OFF);
  assign wrFlags = wrStb && (addr == OFS_FLAGS);

  // ----------------------------------------------------------------
  // Input synchroniser and edge detect
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
    end else begin
      sync1_r <= {indexIn, phaseB, phaseA};
      sync2_r <= sync1_r;
    end
  end

  assign phase_a_input = ctrl_r[CTL_SWAP] ? sync2_r[1] : sync2_r[0];
  assign phase_b_input = ctrl_r[CTL_SWAP] ? sync2_r[0] : sync2_r[1];
  assign index_input = sync2_r[2];

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      aPrev_r <= 1'b0;
      bPrev_r <= 1'b0;
      zPrev_r <= 1'b0;
    end else begin
      aPrev_r <= phase_a_input;
      bPrev_r <= phase_b_input;
      zPrev_r <= index_input;
    end
  end

  assign aRise = phase_a_input & ~aPrev_r;
  assign aFall = ~phase_a_input & aPrev_r;
  assign bRise = phase_b_input & ~bPrev_r;
  assign bFall = ~phase_b_input & bPrev_r;
  assign aEdge = aRise | aFall;
  assign bEdge = bRise | bFall;
  assign zRise = index_input & ~zPrev_r;

  // ----------------------------------------------------------------
  // Position step decode
  // ----------------------------------------------------------------
  always_comb begin
    stepUp = 1'b0;
    stepDn = 1'b0;
    if (!(aEdge && bEdge) && (clearSel || index_input)) begin
      case (posMode)
        POS_UPDN: begin
          stepUp = aRise;
          stepDn = bRise;
        end
        POS_PHASE: begin
          if (aEdge) begin
            stepUp = aRise ? ~phase_b_input : phase_b_input;
            stepDn = aRise ? phase_b_input : ~phase_b_input;
          end else if (bEdge) begin
            stepUp = bRise ? phase_a_input : ~phase_a_input;
            stepDn = bRise ? ~phase_a_input : phase_a_input;
          end
        end
        POS_DIR: begin
          stepUp = bRise & phase_a_input;
          stepDn = bRise & ~phase_a_input;
        end
        default: begin
          stepUp = 1'b0;
          stepDn = 1'b0;
        end
      endcase
    end
  end

  assign posStep = stepUp | stepDn;
  assign inversion = posStep && (stepDn != dir_r);
  assign idxEv = zRise && clearSel;
  assign idxUp = posStep ? stepUp : ~dir_r;
  assign ovf = stepUp && (pos_r == maxPos_r);
  assign unf = stepDn && (pos_r == RST_ZERO);
  assign maskable = (revMode == REV_OFF) || (revMode == REV_BOTH);
  assign maskActive = maskable && (maskCnt_r != MASK_NONE) && !inversion;
  assign modeChange = ctrlPrev_r[3:0] != ctrl_r[3:0];

  // ----------------------------------------------------------------
  // Direction bit
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dir_r <= 1'b0;
    end else if (posStep) begin
      dir_r <= stepDn;
    end
  end

  // ----------------------------------------------------------------
  // Position counter
  // ----------------------------------------------------------------
  always_comb begin
    pos_nxt = pos_r;
    if (wrPos) begin
      pos_nxt = wrData;
    end else if (ovf) begin
      pos_nxt = (revMode == REV_INDEX) ? pos_r + ONE : RST_ZERO;
    end else if (unf) begin
      pos_nxt = maxPos_r;
    end else if (idxEv && revMode != REV_WRAP && !maskActive) begin
      pos_nxt = RST_ZERO;
    end else if (stepUp) begin
      pos_nxt = pos_r + ONE;
    end else if (stepDn) begin
      pos_nxt = pos_r - ONE;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pos_r <= RST_ZERO;
    end else begin
      pos_r <= pos_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Revolution counter
  // ----------------------------------------------------------------
  always_comb begin
    revInc = 1'b0;
    revDec = 1'b0;
    case (revMode)
      REV_INDEX: begin
        revInc = idxEv && idxUp;
        revDec = idxEv && !idxUp;
      end
      REV_WRAP: begin
        revInc = ovf;
        revDec = unf;
      end
      REV_BOTH: begin
        revInc = !maskActive && ((idxEv && idxUp) || ovf);
        revDec = !maskActive && ((idxEv && !idxUp) || unf);
      end
      default: begin
        revInc = 1'b0;
        revDec = 1'b0;
      end
    endcase
  end

  always_comb begin
    rev_nxt = rev_r;
    if (wrRev) begin
      rev_nxt = wrData;
    end else if (revInc) begin
      rev_nxt = rev_r + ONE;
    end else if (revDec) begin
      rev_nxt = rev_r - ONE;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rev_r <= RST_ZERO;
    end else begin
      rev_r <= rev_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Reset mask counter
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      maskCnt_r <= MASK_NONE;
      ctrlPrev_r <= '0;
    end else begin
      ctrlPrev_r <= ctrl_r;
      if (inversion || modeChange || !maskable) begin
        maskCnt_r <= MASK_NONE;
      end else if (idxEv || ovf || unf) begin
        maskCnt_r <= ctrl_r[CTL_MASK +: 2];
      end else if (posStep && maskCnt_r != MASK_NONE) begin
        maskCnt_r <= maskCnt_r - 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Flags and interrupt
  // ----------------------------------------------------------------
  always_comb begin
    flagSet = '0;
    flagSet[FLG_CDC] = inversion;
    flagSet[FLG_IDX] = idxEv && revMode != REV_WRAP && !maskActive;
    flagSet[FLG_OVF] = ovf;
    flagSet[FLG_UNF] = unf;
    flagSet[FLG_SHR] = ctrl_r[CTL_RSEL] ? (rev_r == shrCmp_r) : (pos_r == shrCmp_r);
    flagSet[FLG_POS] = pos_r == posCmp_r;
    flagSet[FLG_DUAL] = (pos_r == posCmp_r) && (rev_r == shrCmp_r);
    flagSet[FLG_OOR] = (revInc && rev_r == ALL_ONES) || (revDec && rev_r == RST_ZERO);
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      flags_r <= '0;
    end else if (wrFlags) begin
      flags_r <= (flags_r & wrData[FLG_N-1:0]) | flagSet;
    end else begin
      flags_r <= flags_r | flagSet;
    end
  end

  assign irq = (flags_r[FLG_CDC] & irqEn_r[EN_CDC])
    | (|flags_r[FLG_UNF:FLG_IDX] & irqEn_r[EN_WRAP])
    | (flags_r[FLG_SHR] & irqEn_r[EN_SHR])
    | (flags_r[FLG_POS] & irqEn_r[EN_POS])
    | (flags_r[FLG_DUAL] & irqEn_r[EN_DUAL])
    | (flags_r[FLG_OOR] & irqEn_r[EN_OOR]);

  // ----------------------------------------------------------------
  // Register writes and reads
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_r <= '0;
      maxPos_r <= RST_MAXPOS;
      posCmp_r <= RST_ZERO;
      shrCmp_r <= RST_ZERO;
      irqEn_r <= '0;
    end else if (wrStb) begin
      case (addr)
        OFS_CTRL: ctrl_r <= wrData[CTL_W-1:0];
        OFS_MAXPOS: maxPos_r <= wrData;
        OFS_POSCMP: posCmp_r <= wrData;
        OFS_SHRCMP: shrCmp_r <= wrData;
        OFS_IRQEN: irqEn_r <= wrData[EN_N-1:0];
        default: ctrl_r <= ctrl_r;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdData_r <= RST_ZERO;
    end else if (rdStb) begin
      case (addr)
        OFS_CTRL: rdData_r <= {{(DATA_W-CTL_W){1'b0}}, ctrl_r};
        OFS_POS: rdData_r <= pos_r;
        OFS_REV: rdData_r <= rev_r;
        OFS_MAXPOS: rdData_r <= maxPos_r;
        OFS_POSCMP: rdData_r <= posCmp_r;
        OFS_SHRCMP: rdData_r <= shrCmp_r;
        OFS_FLAGS: rdData_r <= {{(DATA_W-FLG_N-1){1'b0}}, dir_r, flags_r};
        OFS_IRQEN: rdData_r <= {{(DATA_W-EN_N){1'b0}}, irqEn_r};
        default: rdData_r <= RST_ZERO;
      endcase
    end else begin
      rdData_r <= RST_ZERO;
    end
  end

  assign rdData = rdData_r;
  assign posCount = pos_r;
  assign revCount = rev_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence revHeld;
    rev_r == $past(rev_r);
  endsequence

  sequence revUpOne;
    rev_r == $past(rev_r) + ONE;
  endsequence

  chk_rev_off_hold: assert property (
    (revMode == REV_OFF && !wrRev) |=> revHeld)
    else $error("revolution count moved while disabled");

  chk_index_only: assert property (
    (revMode == REV_INDEX && !idxEv && !wrRev && !modeChange) |=> revHeld)
    else $error("index mode revolution moved without index");

  chk_index_up: assert property (
    (revMode == REV_INDEX && idxEv && !posStep && !dir_r && !wrRev) |=> revUpOne)
    else $error("index edge did not count up");

  chk_ovf_no_reset: assert property (
    (revMode == REV_INDEX && ovf && !wrPos) |=> (pos_r == $past(pos_r) + ONE) && flags_r[FLG_OVF])
    else $error("overflow in index mode mishandled");

  chk_wrap_count: assert property (
    (revMode == REV_WRAP && ovf && !wrRev && !wrPos) |=> revUpOne ##0 (pos_r == RST_ZERO))
    else $error("overflow did not wrap position and count revolution");

  chk_unf_reload: assert property (
    (unf && !wrPos) |=> (pos_r == $past(maxPos_r)) && flags_r[FLG_UNF])
    else $error("underflow did not reload maximum");

  chk_inversion_mask: assert property (
    inversion |=> (maskCnt_r == MASK_NONE))
    else $error("inversion left mask counter set");

  chk_mask_hold_rev: assert property (
    (revMode == REV_BOTH && maskActive && !wrRev && !modeChange) |=> revHeld)
    else $error("revolution counted while masked");

  chk_flag_sticky: assert property (
    (flags_r[FLG_OVF] && !wrFlags) |=> flags_r[FLG_OVF])
    else $error("overflow flag dropped without clear");

  chk_irq_wrap: assert property (
    (ovf && irqEn_r[EN_WRAP] && !(wrStb && addr == OFS_IRQEN)) |=> irq)
    else $error("enabled overflow raised no interrupt");

endmodule : qrc_counter

`default_nettype wire
